//--- cbk_cfg.svh
`ifndef CBK_CFG_SVH
`define CBK_CFG_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define CBK_A_CTRL     8'h00
`define CBK_A_OTGCFG   8'h01
`define CBK_A_OTG_VOLTAGE_TARGET_LO  8'h02
`define CBK_A_OTG_VOLTAGE_TARGET_HI  8'h03
`define CBK_A_OTG_CURRENT_LIMIT     8'h04
`define CBK_A_HOT      8'h05
`define CBK_A_COLD     8'h06
`define CBK_A_VINREG   8'h07
`define CBK_A_STATUS   8'h08
`define CBK_A_FLAGS    8'h09
`define CBK_A_MASK     8'h0A
`define CBK_A_RETURN   8'h16

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define CBK_B_HIZ      0
`define CBK_B_ADC      1
`define CBK_B_OTG      2
`define CBK_B_BKUP     3
`define CBK_B_DRVDIS   4
`define CBK_B_DRV1     5
`define CBK_B_DRV2     6
`define CBK_B_PFMDIS   0
`define CBK_B_AUDDIS   1
`define CBK_B_FIN      0
`define CBK_B_FDIS     1
`define CBK_B_RET      0

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define CBK_RST_OTGCFG 8'h0C
`define CBK_RST_OTG_VOLTAGE_TARGET   11'h1F4
`define CBK_RST_OTG_CURRENT_LIMIT   7'h4B
`define CBK_RST_HOT    8'h30
`define CBK_RST_COLD   8'hC0
`define CBK_RST_VINREG 8'h24
`define CBK_RST_MASK   2'h0

// ---------------------------------------------------------------
// codes and tables
// ---------------------------------------------------------------
`define CBK_VSTAT_BKUP 4'hC
`define CBK_VSTAT_ADPT 4'h7
`define CBK_VSTAT_NONE 4'h0
`define CBK_IDIS_OFF   2'h3
`define CBK_IDIS_3A    8'h1E
`define CBK_IDIS_4A    8'h28
`define CBK_IDIS_5A    8'h32
`define CBK_BR_0       8'h4D
`define CBK_BR_1       8'h5A
`define CBK_BR_2       8'h66
`define CBK_BR_3       8'h73
`define CBK_OVP_0      8'h40
`define CBK_OVP_1      8'h80
`define CBK_OVP_2      8'hB0
`define CBK_OVP_3      8'hF0

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CBK_OTG_DLY_MS 5
`define CBK_CLK_KHZ    50000
`define CBK_OTG_DLY_CY (`CBK_OTG_DLY_MS * `CBK_CLK_KHZ)

`endif

//--- cbk_discharge_reg.sv
`timescale 1ns/1ns
`include "cbk_cfg.svh"
module cbk_discharge_reg
  import cbk_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       ce,
  input  wire logic       otg_active,
  input  wire logic [1:0] limit_code,
  input  wire logic [7:0] current,
  output logic            status_r,
  output logic            rise_r,
  output logic            soft_start,
  output logic            cut
);
  logic [7:0] limit;
  logic       over;

  assign limit      = cbk_sel4(limit_code, `CBK_IDIS_3A, `CBK_IDIS_4A, `CBK_IDIS_5A, 8'hFF);
  assign soft_start = limit_code != `CBK_IDIS_OFF;
  assign over       = otg_active & soft_start & (current > limit);

  // ---------------------------------------------------------------
  // regulation status
  // ---------------------------------------------------------------
  // discharge over limit
  always_ff @(posedge mclk) begin
    if (reset) begin
      status_r <= 1'b0;
      rise_r   <= 1'b0;
    end else if (ce) begin
      status_r <= over;
      rise_r   <= over & ~status_r;
    end
  end

  assign cut = status_r;

endmodule // cbk_discharge_reg

//--- cbk_host.sv
`timescale 1ns/1ns
// ------
// host model
// ------
module cbk_host (
  input  wire logic       mclk,
  input  wire logic [7:0] rdata,
  output logic      [7:0] addr = 8'h00,
  output logic      [7:0] wdata = 8'h00,
  output logic            wr_stb = 1'b0,
  output logic            rd_stb = 1'b0
);
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic ret(output logic [7:0] c);
    wr(8'h16, 8'h01);
    rd(8'h00, c);
    if (c[5]) wr(8'h00, c & 8'hFB);
  endtask
endmodule // cbk_host

//--- cbk_otg_start.sv
`timescale 1ns/1ns
`include "cbk_cfg.svh"
module cbk_otg_start
  import cbk_pkg::*;
#(
  parameter int DELAY = `CBK_OTG_DLY_CY,
  parameter int CNT_W = 18
) (
  input  wire logic      mclk,
  input  wire logic      reset,
  input  wire logic      ce,
  input  wire logic      request,
  input  wire logic      fast,
  input  wire cbk_gate_t gate,
  output logic           run
);
  logic [CNT_W-1:0] cnt_r;
  logic             done_r;
  logic             ungated;
  logic             drive_ok;

  assign ungated  = gate.drive_dis | ~(gate.pair1 | gate.pair2);
  assign drive_ok = (gate.pair1 & gate.drive1) | (gate.pair2 & gate.drive2);

  // ---------------------------------------------------------------
  // start delay timer
  // ---------------------------------------------------------------
  // delayed start ungated
  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt_r  <= '0;
      done_r <= 1'b0;
    end else if (ce) begin
      if (!request) begin
        cnt_r  <= '0;
        done_r <= 1'b0;
      end else if (!done_r) begin
        if (cnt_r == CNT_W'(DELAY - 1)) begin
          done_r <= 1'b1;
        end
        cnt_r <= cnt_r + CNT_W'(1);
      end
    end
  end

  assign run = request & (ungated ? (done_r | fast) : drive_ok);

endmodule // cbk_otg_start

//--- cbk_pkg.sv
package cbk_pkg;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CBK_FWD    = 2'b00,
    CBK_BACKUP = 2'b01,
    CBK_RETURN = 2'b10
  } cbk_mode_t;

  typedef struct packed {
    logic pair1;
    logic pair2;
    logic drive_dis;
    logic drive1;
    logic drive2;
  } cbk_gate_t;

  typedef struct packed {
    logic [1:0] ovp_sel;
    logic [1:0] bkup_sel;
    logic [1:0] dis_limit;
    logic       audio_dis;
    logic       pfm_dis;
  } cbk_otgcfg_t;

  function automatic logic [7:0] cbk_sel4(input logic [1:0] code, input logic [7:0] a,
                                          input logic [7:0] b, input logic [7:0] c,
                                          input logic [7:0] d);
    case (code)
      2'h0:    cbk_sel4 = a;
      2'h1:    cbk_sel4 = b;
      2'h2:    cbk_sel4 = c;
      default: cbk_sel4 = d;
    endcase
  endfunction

endpackage

//--- cbk_top.sv
`timescale 1ns/1ns
`include "cbk_cfg.svh"
module cbk_top
  import cbk_pkg::*;
#(
  parameter int OTG_DLY_CY = `CBK_OTG_DLY_CY,
  parameter int CNT_W      = 18
) (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [7:0]  rdata,
  input  wire logic        pair1_detect,
  input  wire logic        pair2_detect,
  input  wire logic        input_rail_high,
  input  wire logic [7:0]  input_voltage,
  input  wire logic        battery_above_otg_rise,
  input  wire logic        battery_below_otg_cutoff,
  input  wire logic        battery_overvoltage_fault,
  input  wire logic        input_below_uvlo,
  input  wire logic [7:0]  thermistor_reading,
  input  wire logic        input_overvoltage_fault,
  input  wire logic        system_overvoltage_fault,
  input  wire logic        output_overvoltage_fault,
  input  wire logic        system_short_fault,
  input  wire logic        input_overcurrent_fault,
  input  wire logic [7:0]  discharge_current,
  output logic             internal_regulator_on,
  output logic             converter_switching,
  output logic             adc_on,
  output logic             battery_switch_on,
  output logic             forward_charging,
  output logic             otg_active,
  output logic      [10:0] otg_voltage_target,
  output logic      [6:0]  otg_current_limit,
  output logic             pfm_enable,
  output logic             audio_floor_enable,
  output logic             otg_current_cut,
  output logic             soft_start_en,
  output logic             drive1_on,
  output logic             drive2_on,
  output logic      [7:0]  backup_threshold,
  output logic             int_pulse,
  output logic             fast_rearm
);

  logic        hiz_r;
  logic        adc_en_r;
  logic        otg_en_r;
  logic        bkup_en_r;
  logic        drv_dis_r;
  logic        drv1_r;
  logic        drv2_r;
  logic        ret_r;
  cbk_otgcfg_t cfg_r;
  logic [10:0] otg_voltage_target_r;
  logic [6:0]  otg_current_limit_r;
  logic [7:0]  hot_r;
  logic [7:0]  cold_r;
  logic [7:0]  vinreg_r;
  logic [3:0]  vstat_r;
  logic        fin_r;
  logic        fdis_r;
  logic [1:0]  mask_r;
  logic        pair1_r;
  logic        pair2_r;
  logic        cap_done_r;
  logic [7:0]  rdata_r;
  logic        int_r;
  logic        rearm_r;
  cbk_mode_t   mode_r;
  cbk_gate_t   gate;
  logic        wr_ctrl;
  logic        wr_ret;
  logic        allowed;
  logic        therm_ok;
  logic        below_bkup;
  logic        in_ovp;
  logic        trigger;
  logic        otg_host_clear;
  logic        bkup_exit;
  logic        ovp_any;
  logic        conv_run;
  logic        dis_status;
  logic        dis_rise;

  assign wr_ctrl = wr_stb && addr == `CBK_A_CTRL;
  assign wr_ret  = wr_stb && addr == `CBK_A_RETURN && wdata[`CBK_B_RET];

  // ---------------------------------------------------------------
  // strap capture
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      pair1_r    <= 1'b0;
      pair2_r    <= 1'b0;
      cap_done_r <= 1'b0;
    end else if (ce && !cap_done_r) begin
      pair1_r    <= pair1_detect;
      pair2_r    <= pair2_detect;
      cap_done_r <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // qualifiers
  // ---------------------------------------------------------------
  // otg entry conditions
  assign therm_ok = thermistor_reading > hot_r && thermistor_reading < cold_r;
  assign allowed  = battery_above_otg_rise & ~battery_overvoltage_fault & therm_ok &
                    (input_below_uvlo | mode_r != CBK_FWD);
  assign backup_threshold = 8'((16'(vinreg_r) * 16'(cbk_sel4(cfg_r.bkup_sel, `CBK_BR_0, `CBK_BR_1,
                                `CBK_BR_2, `CBK_BR_3))) >> 7);
  assign below_bkup = input_voltage < backup_threshold;
  assign in_ovp  = input_voltage > cbk_sel4(cfg_r.ovp_sel, `CBK_OVP_0, `CBK_OVP_1, `CBK_OVP_2, `CBK_OVP_3);
  assign trigger = mode_r == CBK_FWD && bkup_en_r && pair1_r && (below_bkup || in_ovp);
  assign otg_host_clear = wr_ctrl && otg_en_r && !wdata[`CBK_B_OTG];
  assign bkup_exit = mode_r == CBK_BACKUP && (battery_below_otg_cutoff || otg_host_clear);

  // ---------------------------------------------------------------
  // hiz and adc
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      hiz_r    <= 1'b0;
      adc_en_r <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl) begin
        hiz_r    <= wdata[`CBK_B_HIZ];
        adc_en_r <= wdata[`CBK_B_ADC];
        if (wdata[`CBK_B_HIZ] && !hiz_r) begin
          adc_en_r <= 1'b0;
        end
      end
      if (system_short_fault || input_overcurrent_fault) begin
        hiz_r <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // otg enable
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      otg_en_r <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl) begin
        if (!wdata[`CBK_B_OTG] || !input_rail_high) begin
          otg_en_r <= wdata[`CBK_B_OTG];
        end
      end
      if (battery_below_otg_cutoff && mode_r == CBK_BACKUP) begin
        otg_en_r <= 1'b0;
      end
      if (trigger) begin
        otg_en_r <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // backup arming
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      bkup_en_r <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl && (input_rail_high || !wdata[`CBK_B_BKUP])) begin
        bkup_en_r <= wdata[`CBK_B_BKUP];
      end
      if (wr_ret) begin
        bkup_en_r <= 1'b0;
      end
      if (otg_host_clear && ret_r) begin
        bkup_en_r <= 1'b1;
      end
      if (!input_rail_high) begin
        bkup_en_r <= 1'b0;
      end
      if (!pair1_r) begin
        bkup_en_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // input switch drives and return bit
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      drv_dis_r <= 1'b0;
      drv1_r    <= 1'b0;
      drv2_r    <= 1'b0;
      ret_r     <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl) begin
        drv_dis_r <= wdata[`CBK_B_DRVDIS];
        drv1_r    <= wdata[`CBK_B_DRV1];
        drv2_r    <= wdata[`CBK_B_DRV2];
      end
      if (wr_stb && addr == `CBK_A_RETURN) begin
        ret_r <= wdata[`CBK_B_RET];
      end
      if (wr_ret) begin
        drv_dis_r <= 1'b0;
        drv1_r    <= 1'b1;
      end
      if (otg_host_clear && ret_r) begin
        ret_r <= 1'b0;
      end
      if (trigger) begin
        drv_dis_r <= 1'b1;
      end
      if (in_ovp) begin
        drv1_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // backup mode state
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      mode_r  <= CBK_FWD;
      rearm_r <= 1'b0;
    end else if (ce) begin
      rearm_r <= otg_host_clear && ret_r;
      case (mode_r)
        CBK_FWD: begin
          if (trigger) begin
            mode_r <= CBK_BACKUP;
          end
        end
        CBK_BACKUP: begin
          if (bkup_exit) begin
            mode_r <= CBK_FWD;
          end else if (wr_ret) begin
            mode_r <= CBK_RETURN;
          end
        end
        CBK_RETURN: begin
          if (!otg_en_r) begin
            mode_r <= CBK_FWD;
          end
        end
        default: begin
          mode_r <= CBK_FWD;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // status, flags, interrupt pulse
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      vstat_r <= `CBK_VSTAT_NONE;
      fin_r   <= 1'b0;
      fdis_r  <= 1'b0;
      int_r   <= 1'b0;
    end else if (ce) begin
      vstat_r <= (mode_r == CBK_BACKUP) ? `CBK_VSTAT_BKUP :
                 input_rail_high ? `CBK_VSTAT_ADPT : `CBK_VSTAT_NONE;
      if (wr_stb && addr == `CBK_A_FLAGS) begin
        fin_r  <= fin_r & ~wdata[`CBK_B_FIN];
        fdis_r <= fdis_r & ~wdata[`CBK_B_FDIS];
      end
      if (trigger && !mask_r[`CBK_B_FIN]) begin
        fin_r <= 1'b1;
      end
      if (dis_rise && !mask_r[`CBK_B_FDIS]) begin
        fdis_r <= 1'b1;
      end
      int_r <= trigger | dis_rise;
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      cfg_r    <= `CBK_RST_OTGCFG;
      otg_voltage_target_r   <= `CBK_RST_OTG_VOLTAGE_TARGET;
      otg_current_limit_r   <= `CBK_RST_OTG_CURRENT_LIMIT;
      hot_r    <= `CBK_RST_HOT;
      cold_r   <= `CBK_RST_COLD;
      vinreg_r <= `CBK_RST_VINREG;
      mask_r   <= `CBK_RST_MASK;
    end else if (ce && wr_stb) begin
      case (addr)
        `CBK_A_OTGCFG:  cfg_r         <= wdata;
        `CBK_A_OTG_VOLTAGE_TARGET_LO: otg_voltage_target_r[7:0]   <= wdata;
        `CBK_A_OTG_VOLTAGE_TARGET_HI: otg_voltage_target_r[10:8]  <= wdata[2:0];
        `CBK_A_OTG_CURRENT_LIMIT:    otg_current_limit_r        <= wdata[6:0];
        `CBK_A_HOT:     hot_r         <= wdata;
        `CBK_A_COLD:    cold_r        <= wdata;
        `CBK_A_VINREG:  vinreg_r      <= wdata;
        `CBK_A_MASK:    mask_r        <= wdata[1:0];
        default:        mask_r        <= mask_r;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata_r <= 8'h00;
    end else if (ce) begin
      rdata_r <= 8'h00;
      if (rd_stb) begin
        case (addr)
          `CBK_A_CTRL:    rdata_r <= {1'b0, drv2_r, drv1_r, drv_dis_r, bkup_en_r, otg_en_r, adc_en_r, hiz_r};
          `CBK_A_OTGCFG:  rdata_r <= cfg_r;
          `CBK_A_OTG_VOLTAGE_TARGET_LO: rdata_r <= otg_voltage_target_r[7:0];
          `CBK_A_OTG_VOLTAGE_TARGET_HI: rdata_r <= {5'h00, otg_voltage_target_r[10:8]};
          `CBK_A_OTG_CURRENT_LIMIT:    rdata_r <= {1'b0, otg_current_limit_r};
          `CBK_A_HOT:     rdata_r <= hot_r;
          `CBK_A_COLD:    rdata_r <= cold_r;
          `CBK_A_VINREG:  rdata_r <= vinreg_r;
          `CBK_A_STATUS:  rdata_r <= {conv_run, pair2_r, pair1_r, dis_status, vstat_r};
          `CBK_A_FLAGS:   rdata_r <= {6'h00, fdis_r, fin_r};
          `CBK_A_MASK:    rdata_r <= {6'h00, mask_r};
          `CBK_A_RETURN:  rdata_r <= {7'h00, ret_r};
          default:        rdata_r <= 8'h00;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // converter start and discharge regulation
  // ---------------------------------------------------------------
  assign gate = '{pair1: pair1_r, pair2: pair2_r, drive_dis: drv_dis_r, drive1: drv1_r, drive2: drv2_r};

  cbk_otg_start #(
    .DELAY (OTG_DLY_CY),
    .CNT_W (CNT_W)
  ) u_start (
    .mclk    (mclk),
    .reset   (reset),
    .ce      (ce),
    .request (otg_active),
    .fast    (mode_r == CBK_BACKUP),
    .gate    (gate),
    .run     (conv_run)
  );

  cbk_discharge_reg u_dis (
    .mclk       (mclk),
    .reset      (reset),
    .ce         (ce),
    .otg_active (otg_active),
    .limit_code (cfg_r.dis_limit),
    .current    (discharge_current),
    .status_r   (dis_status),
    .rise_r     (dis_rise),
    .soft_start (soft_start_en),
    .cut        (otg_current_cut)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign ovp_any = input_overvoltage_fault | system_overvoltage_fault |
                   battery_overvoltage_fault | output_overvoltage_fault;
  assign otg_active = otg_en_r & allowed & ~hiz_r;
  assign internal_regulator_on = ~hiz_r;
  assign converter_switching = conv_run & ~ovp_any & ~hiz_r;
  assign adc_on              = adc_en_r;
  assign battery_switch_on   = hiz_r | otg_active | ~input_rail_high;
  assign forward_charging    = mode_r == CBK_FWD & ~otg_en_r & ~hiz_r;
  assign otg_voltage_target  = otg_voltage_target_r;
  assign otg_current_limit   = otg_current_limit_r;
  assign pfm_enable          = otg_active & ~cfg_r.pfm_dis;
  assign audio_floor_enable  = otg_active & ~cfg_r.audio_dis;
  assign drive1_on           = drv1_r & ~drv_dis_r;
  assign drive2_on           = drv2_r & ~drv_dis_r;
  assign int_pulse           = int_r;
  assign fast_rearm          = rearm_r;
  assign rdata               = rdata_r;

endmodule // cbk_top

//--- cbk_top_props.sv
`timescale 1ns/1ns
// ------
// checker
// ------
module cbk_top_props (
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic       ce,
  input wire logic       input_overvoltage_fault,
  input wire logic       system_overvoltage_fault,
  input wire logic       output_overvoltage_fault,
  input wire logic       battery_overvoltage_fault,
  input wire logic       system_short_fault,
  input wire logic       input_overcurrent_fault,
  input wire logic       battery_above_otg_rise,
  input wire logic       input_below_uvlo,
  input wire logic [7:0] discharge_current,
  input wire logic       internal_regulator_on,
  input wire logic       converter_switching,
  input wire logic       battery_switch_on,
  input wire logic       otg_active,
  input wire logic       pfm_enable,
  input wire logic       otg_current_cut,
  input wire logic       int_pulse
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  AST_HIZ: assert property (!internal_regulator_on |-> !converter_switching && battery_switch_on)
    else $error("hiz state not quiet");
  AST_OVP: assert property (
    input_overvoltage_fault || system_overvoltage_fault || output_overvoltage_fault || battery_overvoltage_fault
    |-> !converter_switching) else $error("switching during overvoltage");
  AST_SHORT: assert property (ce && (system_short_fault || input_overcurrent_fault) |=> !internal_regulator_on)
    else $error("fault did not force hiz");
  AST_OTG: assert property (otg_active |-> battery_above_otg_rise && !battery_overvoltage_fault && input_below_uvlo)
    else $error("otg active without conditions");
  AST_PFM: assert property (pfm_enable |-> otg_active)
    else $error("pfm enabled outside otg");
  AST_CUT: assert property ($rose(otg_current_cut) |-> $past(otg_active) && $past(discharge_current) > 8'h1E)
    else $error("current cut without excess discharge");
  AST_INT: assert property ($rose(otg_current_cut) |-> ##[0:1] int_pulse)
    else $error("no pulse on discharge regulation");
  AST_PULSE: assert property (int_pulse |=> !int_pulse)
    else $error("interrupt pulse too long");
endmodule // cbk_top_props

bind cbk_top cbk_top_props u_props (.*);

//--- cbk_top_tb.sv
`timescale 1ns/1ns
`include "cbk_cfg.svh"
module cbk_top_tb;
  logic        mclk = 1'b0, reset = 1'b1, ce = 1'b1, fseen = 1'b0, wr_stb, rd_stb;
  logic [7:0]  addr, wdata, rdata, q, backup_threshold, thermistor_reading = 8'h80;
  logic [7:0]  input_voltage = 8'h30, discharge_current = 8'h00;
  logic        pair1_detect = 1'b1, pair2_detect = 1'b0, battery_below_otg_cutoff = 1'b0;
  logic        input_rail_high = 1'b1, battery_above_otg_rise = 1'b1, battery_overvoltage_fault = 1'b0;
  logic        input_below_uvlo = 1'b0, input_overvoltage_fault = 1'b0;
  logic        system_short_fault = 1'b0, input_overcurrent_fault = 1'b0;
  wire logic   system_overvoltage_fault = input_overvoltage_fault;
  wire logic   output_overvoltage_fault = input_overvoltage_fault;
  logic        internal_regulator_on, converter_switching, adc_on, battery_switch_on, forward_charging;
  logic        otg_active, pfm_enable, audio_floor_enable, otg_current_cut, soft_start_en;
  logic        drive1_on, drive2_on, int_pulse, fast_rearm;
  logic [10:0] otg_voltage_target;
  logic [6:0]  otg_current_limit;
  int          errors = 0, checks_done = 0;
  logic [7:0]  lim [3] = '{`CBK_IDIS_3A, `CBK_IDIS_4A, `CBK_IDIS_5A};

  cbk_top #(.OTG_DLY_CY(20), .CNT_W(18)) DUT (.*);
  cbk_host h (.*);
  always #10 mclk = ~mclk;
  always @(posedge mclk) if (fast_rearm === 1'b1) fseen <= 1'b1;

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    h.rd(a, d);
    chk(n, d & m, e);
  endtask
  task final_report;
    if (errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #1000000;
    errors++;
    final_report;
  end
  // ------
  // main sequence
  // ------
  initial begin
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    rc("otgcfg", 8'h01, 8'hFF, `CBK_RST_OTGCFG);
    rc("otg_current_limit", 8'h04, 8'h7F, {1'b0, `CBK_RST_OTG_CURRENT_LIMIT});
    rc("otg_voltage_target_hi", 8'h03, 8'h07, 8'h01);
    rc("unmapped", 8'h20, 8'hFF, 8'h00);
    @(posedge mclk) ce <= 1'b0;
    h.wr(8'h07, 8'h00);
    @(posedge mclk) ce <= 1'b1;
    rc("frozen", 8'h07, 8'hFF, `CBK_RST_VINREG);
    h.wr(8'h00, 8'h04);
    rc("otg_refused", 8'h00, 8'h04, 8'h00);
    h.wr(8'h00, 8'h28);
    rc("backup_en", 8'h00, 8'h08, 8'h08);
    chk("threshold", backup_threshold, 8'h15);
    chk("fwd_on", 8'(forward_charging), 8'h01);
    chk("otg_voltage_target_out", 8'(otg_voltage_target), 8'(`CBK_RST_OTG_VOLTAGE_TARGET));
    chk("otg_current_limit_out", {1'b0, otg_current_limit}, {1'b0, `CBK_RST_OTG_CURRENT_LIMIT});
    @(posedge mclk);
    input_voltage <= 8'h10;
    input_below_uvlo <= 1'b1;
    repeat (3) @(posedge mclk);
    rc("in_status", 8'h08, 8'h0F, `CBK_VSTAT_BKUP);
    rc("forced", 8'h00, 8'h14, 8'h14);
    rc("in_flag", 8'h09, 8'h01, 8'h01);
    chk("fwd_stop", 8'(forward_charging), 8'h00);
    @(posedge mclk);
    input_rail_high <= 1'b0;
    rc("backup_low", 8'h00, 8'h08, 8'h00);
    @(posedge mclk);
    input_rail_high <= 1'b1;
    input_voltage <= 8'h30;
    h.ret(q);
    chk("ret_ctrl", q & 8'h3C, 8'h24);
    chk("drive1", {6'h0, drive2_on, drive1_on}, 8'h01);
    rc("ret_bit", 8'h16, 8'h01, 8'h00);
    rc("rearm", 8'h00, 8'h0C, 8'h08);
    chk("fast", 8'(fseen), 8'h01);
    @(posedge mclk);
    input_rail_high <= 1'b0;
    input_below_uvlo <= 1'b1;
    h.wr(8'h00, 8'h04);
    @(negedge mclk) chk("gated", 8'(converter_switching), 8'h00);
    h.wr(8'h00, 8'h24);
    @(negedge mclk) chk("opened", 8'(converter_switching), 8'h01);
    for (int k = 0; k < 3; k++) begin
      h.wr(8'h01, {4'h0, k[1:0], 2'h0});
      @(posedge mclk) discharge_current <= lim[k];
      repeat (3) @(negedge mclk);
      chk("no_cut", 8'(otg_current_cut), 8'h00);
      chk("soft", 8'(soft_start_en), 8'h01);
      chk("pfm_on", 8'(pfm_enable), 8'h01);
      @(posedge mclk) discharge_current <= lim[k] + 8'h01;
      repeat (3) @(negedge mclk);
      chk("cut", 8'(otg_current_cut), 8'h01);
      @(posedge mclk) discharge_current <= 8'h00;
    end
    rc("dis_flag", 8'h09, 8'h02, 8'h02);
    h.wr(8'h01, 8'h0F);
    @(negedge mclk) chk("pfm_audio", {6'h0, pfm_enable, audio_floor_enable}, 8'h00);
    chk("soft_off", 8'(soft_start_en), 8'h00);
    h.wr(8'h00, 8'h04);
    @(negedge mclk) chk("drive_lost", 8'(converter_switching), 8'h00);
    h.wr(8'h00, 8'h00);
    h.wr(8'h00, 8'h14);
    repeat (20) @(negedge mclk);
    chk("early", 8'(converter_switching), 8'h00);
    @(negedge mclk);
    chk("started", 8'(converter_switching), 8'h01);
    @(posedge mclk) input_overvoltage_fault <= 1'b1;
    @(negedge mclk) chk("ovp_sw", 8'(converter_switching), 8'h00);
    chk("ovp_reg", 8'(internal_regulator_on), 8'h01);
    @(posedge mclk) input_overvoltage_fault <= 1'b0;
    battery_overvoltage_fault <= 1'b1;
    @(negedge mclk) chk("bat_ovp", 8'(otg_active), 8'h00);
    @(posedge mclk) battery_overvoltage_fault <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk) {system_short_fault, input_overcurrent_fault} <= (i == 0) ? 2'b10 : 2'b01;
      @(posedge mclk) {system_short_fault, input_overcurrent_fault} <= 2'b00;
      rc("fault_hiz", 8'h00, 8'h01, 8'h01);
      h.wr(8'h00, 8'h02);
    end
    h.wr(8'h00, 8'h03);
    @(negedge mclk) chk("hiz", {5'h0, adc_on, internal_regulator_on, battery_switch_on}, 8'h01);
    h.wr(8'h00, 8'h03);
    @(negedge mclk) chk("hiz_adc", 8'(adc_on), 8'h01);
    @(posedge mclk) input_rail_high <= 1'b1;
    h.wr(8'h00, 8'h28);
    @(posedge mclk) input_voltage <= 8'h50;
    rc("ovp_entry", 8'h00, 8'h34, 8'h14);
    @(posedge mclk) input_voltage <= 8'h30;
    battery_below_otg_cutoff <= 1'b1;
    rc("cutoff", 8'h00, 8'h04, 8'h00);
    @(posedge mclk) reset <= 1'b1;
    pair1_detect <= 1'b0;
    @(posedge mclk) reset <= 1'b0;
    h.wr(8'h00, 8'h08);
    rc("no_pair1", 8'h00, 8'h08, 8'h00);
    final_report;
  end
endmodule // cbk_top_tb
